// [rtl/bcr_byte_sender.sv]
// Three-byte sample sender with per-byte handshake.
`timescale 1ns/10ps
`default_nettype none
module bcr_byte_sender
  import bcr_pkg::*;
(
  input wire logic mclk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic start_in, // Frame start pulse
  input wire logic [7:0] byte0_in, // First byte
  input wire logic [7:0] byte1_in, // Second byte
  input wire logic [7:0] byte2_in, // Third byte
  input wire logic byte_ready_in, // Link takes current byte
  output logic [7:0] byte_out, // Current byte
  output logic byte_valid_out, // Current byte valid
  output logic busy_out // Frame in progress
);

  // ==========================================================
  // Frame storage
  // ==========================================================
  logic [7:0] hold [BYTES_PER_SAMPLE]; // Latched frame bytes
  logic [1:0] idx; // Index of byte on the link
  wire take = byte_valid_out && byte_ready_in; // Byte accepted
  wire last = (idx == 2'(BYTES_PER_SAMPLE - 1)); // Final byte
  wire load = start_in && !busy_out; // New frame accepted
  wire [1:0] next_idx = load ? 2'h0 : (take ? idx + 2'h1 : idx);

  // Capture whole frame at once so bytes never mix samples
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold[0] <= 8'h00;
      hold[1] <= 8'h00;
      hold[2] <= 8'h00;
    end else if (load) begin
      hold[0] <= byte0_in;
      hold[1] <= byte1_in;
      hold[2] <= byte2_in;
    end
  end

  // Walk through the bytes in fixed order
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      idx <= 2'h0;
      busy_out <= 1'b0;
      byte_valid_out <= 1'b0;
    end else begin
      idx <= next_idx;
      if (load) begin
        busy_out <= 1'b1;
        byte_valid_out <= 1'b1;
      end else if (take && last) begin
        busy_out <= 1'b0;
        byte_valid_out <= 1'b0;
      end
    end
  end

  // Output byte registered from the index it will hold
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      byte_out <= 8'h00;
    end else if (load) begin
      byte_out <= byte0_in;
    end else if (take && !last) begin
      byte_out <= hold[next_idx];
    end
  end

endmodule
`default_nettype wire

// [rtl/bcr_pkg.sv]
// Shared constants for the bridge calibration raw readout block.
package bcr_pkg;

  // ==========================================================
  // Command opcodes (upper byte of a received command word)
  // ==========================================================
  localparam logic [7:0] OP_CONFIG = 8'h30;
  localparam logic [7:0] OP_MODE = 8'h40;
  localparam logic [7:0] OP_ENTER_CMD = 8'h50;
  localparam logic [7:0] OP_SOT = 8'h60;
  localparam logic [7:0] OP_PTAT_REF = 8'h70;
  localparam logic [7:0] OP_GAIN_B_HI = 8'h80;
  localparam logic [7:0] OP_GAIN_B_LO = 8'h90;
  localparam logic [7:0] OP_OFFS_B_HI = 8'hA0;
  localparam logic [7:0] OP_OFFS_B_LO = 8'hB0;
  localparam logic [7:0] OP_GAIN_T = 8'hC0;
  localparam logic [7:0] OP_OFFS_T = 8'hD0;
  localparam logic [7:0] OP_OFFS_DRIFT = 8'hE0;
  localparam logic [7:0] OP_GAIN_DRIFT = 8'hF0;

  // ==========================================================
  // Data field values and positions
  // ==========================================================
  localparam logic [7:0] DATA_NORMAL = 8'h00;
  localparam int RAW_BIT = 4;
  localparam logic [3:0] CFG_SOT_NIBBLE = 4'h7;

  // ==========================================================
  // Unity gains and second-order target codes
  // ==========================================================
  localparam logic [14:0] GAIN_B_UNITY = 15'h0800;
  localparam logic [7:0] GAIN_T_UNITY = 8'h80;
  localparam logic [1:0] SOT_OFF = 2'h0;
  localparam logic [1:0] SOT_TGT_OFFS = 2'h1;
  localparam logic [1:0] SOT_TGT_GAIN = 2'h2;
  localparam logic [1:0] SOT_TGT_LIN = 2'h3;

  // ==========================================================
  // Reset values of the coefficient registers
  // ==========================================================
  localparam logic [14:0] RST_GAIN_B = 15'h0000;
  localparam logic [13:0] RST_OFFS_B = 14'h0000;
  localparam logic [7:0] RST_COEF8 = 8'h00;
  localparam logic [1:0] RST_SOT_CFG = 2'h0;

  // ==========================================================
  // Sample framing
  // ==========================================================
  localparam int BYTES_PER_SAMPLE = 3;
  localparam logic [1:0] ZERO_PAD = 2'h0;

  typedef enum logic [1:0] {
    BCR_NORMAL,
    BCR_COMMAND,
    BCR_RAW
  } bcr_mode_e;

endpackage

// [rtl/bcr_readout.sv]
// Command decode, coefficient store and raw sample output.
//
// Operation
// - Entry word then raw word selects raw
// - Raw mode at unity outputs uncorrected conversions
// - Sample bytes: bridge high, low, temperature
// - Bridge high byte top two bits zero
// - Temperature byte drops three known bits
// - Second-order term drives at most one target
// - Mode word with zero data returns normal
`timescale 1ns/10ps
`default_nettype none
module bcr_readout
  import bcr_pkg::*;
#(
  parameter int BRIDGE_W = 14, // Bridge conversion width
  parameter int TEMP_W = 11 // Temperature resolution carried
)(
  input wire logic mclk_in, // System clock, 125 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic cmd_valid_in, // Command word strobe
  input wire logic [15:0] cmd_word_in, // Opcode byte and data byte
  input wire logic sample_valid_in, // New conversion pair
  input wire logic [BRIDGE_W-1:0] raw_bridge_in, // Raw bridge result
  input wire logic [TEMP_W-1:0] raw_temp_in, // Raw temperature result
  input wire logic [BRIDGE_W-1:0] corr_bridge_in, // Corrected bridge
  input wire logic [TEMP_W-1:0] corr_temp_in, // Corrected temperature
  input wire logic byte_ready_in, // Link takes byte
  output logic [7:0] byte_out, // Output byte
  output logic byte_valid_out, // Output byte valid
  output logic sender_busy_out, // Frame in progress
  output logic command_mode_out, // Command interpret active
  output logic raw_mode_out, // Raw mode active; unprocessed output only at unity gains
  output logic [14:0] gain_b_out, // Bridge gain coefficient
  output logic [13:0] offset_b_out, // Bridge offset coefficient
  output logic [7:0] gain_t_out, // Temperature gain coefficient
  output logic [7:0] offset_t_out, // Temperature offset coefficient
  output logic [7:0] ptat_reference_value_out, // PTAT reference
  output logic [7:0] offset_drift_out, // Offset drift coefficient
  output logic [7:0] gain_drift_out, // Gain drift coefficient
  output logic [7:0] second_order_coeff_out, // Second-order term
  output logic second_order_offset_drift_out, // Term on offset drift
  output logic second_order_gain_drift_out, // Term on gain drift
  output logic second_order_linearity_out // Term on bridge linearity
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Bridge width is fixed by the byte framing; temperature width may be 8 to 11
  // Framing packs bridge into 14 bits and temperature into 8
  if (BRIDGE_W != 14) begin : g_bad_bridge
    $error("bridge width must be 14");
  end
  if (TEMP_W < 8 || TEMP_W > 11) begin : g_bad_temp
    $error("temperature width must be 8 to 11");
  end
  // The sender walks exactly three bytes with a two-bit index
  if (BYTES_PER_SAMPLE != 3) begin : g_bad_frame
    $error("sample must be three bytes");
  end

  // ==========================================================
  // Command decode
  // ==========================================================
  // Outside command mode only the entry word is heard; any
  // other word is dropped without trace, so stray traffic on
  // the line cannot disturb the coefficients.
  bcr_mode_e mode; // Current operating mode
  bcr_mode_e next_mode; // Mode after this cycle
  wire [7:0] op = cmd_word_in[15:8]; // Opcode byte
  wire [7:0] dat = cmd_word_in[7:0]; // Data byte
  wire in_cmd = (mode != BCR_NORMAL); // Raw is a command-mode subset
  wire go_cmd = cmd_valid_in && (op == OP_ENTER_CMD); // Entry word
  wire wr = cmd_valid_in && in_cmd; // Accepted programming word
  wire go_norm = wr && (op == OP_MODE) && (dat == DATA_NORMAL);
  wire go_raw = wr && (op == OP_MODE) && dat[RAW_BIT];
  wire cfg_sot = wr && (op == OP_CONFIG) && (dat[7:4] == CFG_SOT_NIBBLE);

  // Mode selection; leaving wins over re-entry within one word
  // The entry word seen in command or raw mode changes nothing
  always_comb begin
    next_mode = mode;
    if (go_norm) begin
      next_mode = BCR_NORMAL;
    end else if (go_raw) begin
      next_mode = BCR_RAW;
    end else if (go_cmd && mode == BCR_NORMAL) begin
      next_mode = BCR_COMMAND;
    end
  end

  // Mode register and status copies
  // Flags follow next_mode so they change on the same edge
  // as the mode, with no extra cycle of lag
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode <= BCR_NORMAL;
      command_mode_out <= 1'b0;
      raw_mode_out <= 1'b0;
    end else begin
      mode <= next_mode;
      command_mode_out <= (next_mode != BCR_NORMAL);
      raw_mode_out <= (next_mode == BCR_RAW);
    end
  end

  // ==========================================================
  // Coefficient registers
  // ==========================================================
  // Identity lives in the same registers later given final values
  // Writes land only while command or raw mode is active
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ptat_reference_value_out <= RST_COEF8;
      offset_drift_out <= RST_COEF8;
      gain_drift_out <= RST_COEF8;
      second_order_coeff_out <= RST_COEF8;
    end else if (wr) begin
      case (op)
        OP_PTAT_REF: ptat_reference_value_out <= dat;
        OP_OFFS_DRIFT: offset_drift_out <= dat;
        OP_GAIN_DRIFT: gain_drift_out <= dat;
        OP_SOT: second_order_coeff_out <= dat;
        default: begin
          // Other opcodes leave these alone
        end
      endcase
    end
  end

  // Gain and offset halves; top bits of upper halves are dropped
  // A host that leaves those bits set loses them silently;
  // there is no room for them in the register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gain_b_out <= RST_GAIN_B;
      offset_b_out <= RST_OFFS_B;
      gain_t_out <= RST_COEF8;
      offset_t_out <= RST_COEF8;
    end else if (wr) begin
      case (op)
        OP_GAIN_B_HI: gain_b_out[14:8] <= dat[6:0];
        OP_GAIN_B_LO: gain_b_out[7:0] <= dat;
        OP_OFFS_B_HI: offset_b_out[13:8] <= dat[5:0];
        OP_OFFS_B_LO: offset_b_out[7:0] <= dat;
        OP_GAIN_T: gain_t_out <= dat;
        OP_OFFS_T: offset_t_out <= dat;
        default: begin
          // Other opcodes leave these alone
        end
      endcase
    end
  end

  // ==========================================================
  // Second-order target, one-hot or none
  // ==========================================================
  // Only the config word with the target nibble moves it;
  // other config nibbles belong to logic outside this block
  logic [1:0] sot_cfg; // Chosen second-order target
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sot_cfg <= RST_SOT_CFG;
    end else if (cfg_sot) begin
      sot_cfg <= dat[1:0];
    end
  end

  // Single code drives the strobes so two can never be active
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      second_order_offset_drift_out <= 1'b0;
      second_order_gain_drift_out <= 1'b0;
      second_order_linearity_out <= 1'b0;
    end else begin
      second_order_offset_drift_out <= (sot_cfg == SOT_TGT_OFFS);
      second_order_gain_drift_out <= (sot_cfg == SOT_TGT_GAIN);
      second_order_linearity_out <= (sot_cfg == SOT_TGT_LIN);
    end
  end

  // ==========================================================
  // Sample formatting
  // ==========================================================
  // Raw data only when both gains are at unity, as the host arranges
  // Both gains are compared against the package unity codes
  // Selection is latched at frame start, so a mode or gain
  // change mid-frame never splits one sample
  wire unity = (gain_b_out == GAIN_B_UNITY) && (gain_t_out == GAIN_T_UNITY);
  wire use_raw = (mode == BCR_RAW) && unity;
  wire [13:0] sel_bridge = use_raw ? raw_bridge_in : corr_bridge_in;
  wire [TEMP_W-1:0] sel_temp = use_raw ? raw_temp_in : corr_temp_in;
  wire [7:0] b_hi = {ZERO_PAD, sel_bridge[13:8]};
  wire [7:0] b_lo = sel_bridge[7:0];
  // Only the low byte leaves; upper temperature bits are assumed
  wire [7:0] t_byte = sel_temp[7:0];

  // The sender owns the handshake; this level only builds bytes
  // Samples arriving mid-frame are dropped by the sender
  bcr_byte_sender u_sender (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(sample_valid_in),
    .byte0_in(b_hi),
    .byte1_in(b_lo),
    .byte2_in(t_byte),
    .byte_ready_in(byte_ready_in),
    .byte_out(byte_out),
    .byte_valid_out(byte_valid_out),
    .busy_out(sender_busy_out)
  );

endmodule
`default_nettype wire

// [verif/bcr_cal_host.sv]
// Calibration master model: takes sample bytes, fast or slow.
`timescale 1ns/10ps
`default_nettype none
module bcr_cal_host (
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic stall_in, // Accept every other cycle
  input wire logic [7:0] byte_in, // Byte from device
  input wire logic byte_valid_in, // Byte offered
  output logic ready_out // Byte taken when high
);
  logic [7:0] rx_q[$]; // Bytes in arrival order
  logic tick; // Pace toggle
  // Collect each accepted byte for averaging later
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (byte_valid_in && ready_out) rx_q.push_back(byte_in);
    end
  end
  assign ready_out = ~stall_in | tick;
endmodule
`default_nettype wire

// [verif/bcr_readout_sva.sv]
// Port assertions for the raw readout block.
`timescale 1ns/10ps
`default_nettype none
module bcr_readout_sva (
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic cmd_valid_in, // Command strobe
  input wire logic [15:0] cmd_word_in, // Command word
  input wire logic sample_valid_in, // Sample strobe
  input wire logic byte_ready_in, // Link ready
  input wire logic [7:0] byte_out, // Byte
  input wire logic byte_valid_out, // Byte valid
  input wire logic sender_busy_out, // Frame busy
  input wire logic command_mode_out, // Command mode
  input wire logic raw_mode_out, // Raw mode
  input wire logic second_order_offset_drift_out, // Target a
  input wire logic second_order_gain_drift_out, // Target b
  input wire logic second_order_linearity_out // Target c
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ====
  // Mode steps
  sequence s_enter; cmd_valid_in && cmd_word_in == 16'h5000; endsequence
  sequence s_raw; cmd_valid_in && cmd_word_in == 16'h4010; endsequence
  property p_enter; s_enter |=> command_mode_out; endproperty
  a_enter: assert property (p_enter) else $error("entry ignored");
  property p_raw;
    s_enter ##1 !cmd_valid_in ##1 s_raw |=> raw_mode_out;
  endproperty
  a_raw: assert property (p_raw) else $error("raw not entered");
  property p_sub; raw_mode_out |-> command_mode_out; endproperty
  a_sub: assert property (p_sub) else $error("raw outside cmd");
  property p_refuse;
    !command_mode_out && cmd_valid_in && cmd_word_in[15:8] != 8'h50
      |=> !command_mode_out && !raw_mode_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("word taken");
  property p_exit;
    command_mode_out && cmd_valid_in && cmd_word_in == 16'h4000
      |=> !command_mode_out && !raw_mode_out;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_one;
    $onehot0({second_order_offset_drift_out, second_order_gain_drift_out,
      second_order_linearity_out});
  endproperty
  a_one: assert property (p_one) else $error("two targets");
  // ====
  // Sample framing
  property p_start;
    sample_valid_in && !sender_busy_out
      |=> byte_valid_out && sender_busy_out && byte_out[7:6] == 2'h0;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_hold;
    byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_len;
    $rose(byte_valid_out) ##0 byte_ready_in [*3] |=> !byte_valid_out;
  endproperty
  a_len: assert property (p_len) else $error("not 3 bytes");
endmodule
bind bcr_readout bcr_readout_sva u_sva (.mclk_in, .rst_in, .cmd_valid_in,
  .cmd_word_in, .sample_valid_in, .byte_ready_in, .byte_out, .byte_valid_out,
  .sender_busy_out, .command_mode_out, .raw_mode_out,
  .second_order_offset_drift_out, .second_order_gain_drift_out,
  .second_order_linearity_out);
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the raw readout block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, rst = 1'b1, cmd_v = 1'b0, smp_v = 1'b0, stall = 1'b0;
  logic [15:0] cmd_w = 16'h0000; // Command word
  logic [13:0] rb = 14'h0000, cb = 14'h0000; // Bridge values
  logic [10:0] rt = 11'h000, ct = 11'h000; // Temperature values
  logic rdy, bv, busy, cm, rm, so1, so2, so3;
  logic [7:0] bo, gt, ptat, od, gd, ot, soc;
  logic [14:0] gb;
  logic [13:0] ob; // Bridge offset readback
  int n_mismatch = 0, num_checks = 0;
  int sum_b = 0; // Bridge sum for averaging
  always #4 mclk = ~mclk;
  bcr_readout dut (.mclk_in(mclk), .rst_in(rst), .cmd_valid_in(cmd_v),
    .cmd_word_in(cmd_w), .sample_valid_in(smp_v), .raw_bridge_in(rb),
    .raw_temp_in(rt), .corr_bridge_in(cb), .corr_temp_in(ct),
    .byte_ready_in(rdy), .byte_out(bo), .byte_valid_out(bv),
    .sender_busy_out(busy), .command_mode_out(cm), .raw_mode_out(rm),
    .gain_b_out(gb), .offset_b_out(ob), .gain_t_out(gt), .offset_t_out(ot),
    .ptat_reference_value_out(ptat), .offset_drift_out(od),
    .gain_drift_out(gd), .second_order_coeff_out(soc),
    .second_order_offset_drift_out(so1), .second_order_gain_drift_out(so2),
    .second_order_linearity_out(so3));
  bcr_cal_host host (.mclk_in(mclk), .rst_in(rst), .stall_in(stall),
    .byte_in(bo), .byte_valid_in(bv), .ready_out(rdy));
  // ====
  // Tasks
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    @(posedge mclk) begin
      cmd_v <= 1'b1;
      cmd_w <= w;
    end
    @(posedge mclk) cmd_v <= 1'b0;
    #1;
  endtask
  // Second strobe lands while busy and must be dropped
  task automatic frame(input logic [13:0] b, input logic [10:0] t,
      input logic raw);
    int n = 0;
    logic [13:0] nb = ~b;
    logic [10:0] nt = ~t;
    logic [23:0] exp_w;
    exp_w = raw ? {2'h0, b, t[7:0]} : {2'h0, nb, nt[7:0]};
    @(posedge mclk) begin
      smp_v <= 1'b1;
      rb <= b;
      rt <= t;
      cb <= nb;
      ct <= nt;
    end
    @(posedge mclk) begin
      rb <= ~b;
      cb <= b;
    end
    @(posedge mclk) smp_v <= 1'b0;
    while (host.rx_q.size() < 3 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) begin
      n_mismatch++;
      report_and_stop;
    end
    chk({host.rx_q[0], host.rx_q[1], host.rx_q[2]}, exp_w);
    sum_b += int'({host.rx_q[0][5:0], host.rx_q[1]});
    repeat (8) @(posedge mclk);
    chk(24'(host.rx_q.size()), 24'h3);
    host.rx_q.delete();
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    cmd(16'h4010);
    chk({rm, cm}, 24'h0);
    frame(14'h2A5C, 11'h5B3, 1'b0);
    cmd(16'h5000);
    chk(24'(cm), 24'h1);
    cmd(16'h70A5);
    cmd(16'hF05A);
    cmd(16'hE0C3);
    chk({ptat, gd, od}, 24'hA55AC3);
    cmd(16'h8008);
    cmd(16'h9000);
    cmd(16'hC080);
    chk({1'b0, gb, gt}, 24'h080080);
    cmd(16'h4010);
    chk({rm, cm}, 24'h3);
    stall <= 1'b1;
    frame(14'h1234, 11'h6EF, 1'b1);
    stall <= 1'b0;
    frame(14'h3FFF, 11'h7FF, 1'b1);
    // Three points of sixteen raw readings, each averaged
    for (int p = 1; p <= 3; p++) begin
      sum_b = 0;
      for (int i = 0; i < 16; i++) begin
        frame(14'(p * 16'h0400 + i), 11'h5A5, 1'b1);
      end
      chk(24'(sum_b / 16), 24'(p * 16'h0400 + 7));
    end
    cmd(16'hC081);
    frame(14'h0F0F, 11'h2A1, 1'b0);
    // Two-point result: bridge gain and offset only
    cmd(16'h8009);
    cmd(16'h9034);
    cmd(16'hA015);
    cmd(16'hB0AA);
    chk(24'(gb), 24'h000934);
    chk(24'(ob), 24'h0015AA);
    // Third point adds first-order offset drift
    cmd(16'hE05C);
    chk(24'(od), 24'h00005C);
    cmd(16'h70FF);
    chk(24'(ptat), 24'h0000FF);
    cmd(16'hD03C);
    chk(24'(ot), 24'h00003C);
    cmd(16'h6077);
    chk(24'(soc), 24'h000077);
    for (int k = 0; k < 4; k++) begin
      cmd(16'h3070 | 16'(k));
      @(posedge mclk);
      #1;
      chk({so3, so2, so1}, k == 0 ? 24'h0 : 24'(1 << (k - 1)));
    end
    cmd(16'h4000);
    chk({rm, cm}, 24'h0);
    // Entry word then raw word, one idle cycle apart
    cmd(16'h5000);
    cmd(16'h4010);
    chk({rm, cm}, 24'h3);
    cmd(16'h4000);
    chk({rm, cm}, 24'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
